// >>> hdl/dbhp_top.sv
// Diskette buffer host port: microbus decode, buffer, write sequencer, AXI4-Lite registers
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module dbhp_top #(
  parameter logic [7:0] ID_CODE = dbhp_pkg::ID_CODE_DEF,  // Arbitrary value
  parameter int BUF_DEPTH = 256
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] cmd_addr_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic in_strobe_n,
  input wire logic out_strobe_n,
  output logic irq_n,
  input wire logic irq_ack_n,
  input wire logic [3:0] jumper_addr,
  input wire logic byte_tick,
  input wire logic skip_byte_seen,
  input wire logic dc_gap_found,
  output logic wr_gate,
  output logic [7:0] wr_byte,
  output logic wr_byte_valid,
  output logic wr_fm,
  output logic wr_silent,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  initial begin
    if (BUF_DEPTH != 256) begin
      $error("dbhp_top: buffer logic serves exactly 256 bytes");
    end
  end

  // ---------------- Microbus decode ----------------
  logic [7:0] ca;  // True-sense command/address
  logic [3:0] cmd;
  logic sel;  // This device addressed
  logic in_prev_q;
  logic out_prev_q;
  logic in_rise;
  logic out_fall;
  logic out_rise;
  logic [7:0] wdata_q;  // Byte latched at output strobe leading edge
  logic [7:0] in_data_q;  // Prefetched buffer byte for reading
  logic [7:0] stat_byte_q;  // Status byte kept by software
  logic [3:0] jmp_q;  // Jumper setting, sampled every cycle

  always_comb begin
    ca = ~cmd_addr_n;
    cmd = ca[dbhp_pkg::CMD_LSB +: 4];
    sel = (ca[dbhp_pkg::ADDR_LSB +: 4] == jmp_q);
    in_rise = !in_prev_q && in_strobe_n && sel;
    out_fall = out_prev_q && !out_strobe_n && sel;
    out_rise = !out_prev_q && out_strobe_n && sel;
  end

  // Strobe history for edge detection; jumpers are static straps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_prev_q <= 1'b1;
      out_prev_q <= 1'b1;
      jmp_q <= 4'h0;
    end else begin
      in_prev_q <= in_strobe_n;
      out_prev_q <= out_strobe_n;
      jmp_q <= jumper_addr;
    end
  end

  // Data drive: only while addressed and the input strobe is held low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else if (!in_strobe_n && sel) begin
      data_oe <= 1'b1;
      case (cmd)
        dbhp_pkg::CMD_STATUS_RD: data_out <= stat_byte_q;
        dbhp_pkg::CMD_ID_RD: data_out <= ID_CODE;
        dbhp_pkg::CMD_BUF_RD: data_out <= in_data_q;
        default: data_out <= 8'h00;
      endcase
    end else begin
      data_oe <= 1'b0;
      data_out <= 8'h00;
    end
  end

  // Capture output data at the leading edge of the output strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdata_q <= 8'h00;
    end else if (out_fall) begin
      wdata_q <= data_in;
    end
  end

  // ---------------- Pointers and buffer ----------------
  logic [7:0] hptr;
  logic [7:0] dptr;
  logic hptr_load;
  logic hptr_inc;
  logic dptr_clr;
  logic dptr_inc;
  logic page_q;  // Disk page select
  logic hreq_q;  // Host access waiting for the buffer
  logic hwe_q;
  logic hinc_pend_q;  // Advance host pointer when the write is granted
  logic dreq_q;
  logic h_gnt;
  logic d_gnt;
  logic [7:0] h_rdata;
  logic h_rvalid;
  logic [7:0] d_rdata;
  logic d_rvalid;
  logic [7:0] d_addr;

  always_comb begin
    hptr_load = out_rise && (cmd == dbhp_pkg::CMD_LOAD_HPTR);
    hptr_inc = (in_rise && (cmd == dbhp_pkg::CMD_BUF_RD))
      || (hinc_pend_q && h_gnt);
    dptr_clr = out_rise && (cmd == dbhp_pkg::CMD_LOAD_PAGE);
    d_addr = dptr + {page_q, 7'h00};  // Offset inside the selected half
  end

  dbhp_ptr #(.W(8)) u_hptr (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(hptr_load),
    .load_val(wdata_q),
    .inc(hptr_inc),
    .ptr(hptr)
  );

  dbhp_ptr #(.W(8)) u_dptr (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(dptr_clr),
    .load_val(8'h00),
    .inc(dptr_inc),
    .ptr(dptr)
  );

  dbhp_buf #(.DEPTH(BUF_DEPTH), .AW(8)) u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .h_req(hreq_q),
    .h_we(hwe_q),
    .h_addr(hptr),
    .h_wdata(wdata_q),
    .h_gnt(h_gnt),
    .h_rdata(h_rdata),
    .h_rvalid(h_rvalid),
    .d_req(dreq_q),
    .d_addr(d_addr),
    .d_gnt(d_gnt),
    .d_rdata(d_rdata),
    .d_rvalid(d_rvalid)
  );

  // Disk page register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_q <= 1'b0;
    end else if (dptr_clr) begin
      page_q <= wdata_q[dbhp_pkg::PAGE_BIT];
    end
  end

  // Host buffer requests; a read fetches the byte at the pointer after it moves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hreq_q <= 1'b0;
      hwe_q <= 1'b0;
      hinc_pend_q <= 1'b0;
    end else if (out_rise && (cmd == dbhp_pkg::CMD_BUF_WR)) begin
      hreq_q <= 1'b1;
      hwe_q <= 1'b1;
      hinc_pend_q <= 1'b1;
    end else if (hptr_load || (in_rise && (cmd == dbhp_pkg::CMD_BUF_RD))) begin
      hreq_q <= 1'b1;
      hwe_q <= 1'b0;
      hinc_pend_q <= 1'b0;
    end else if (h_gnt) begin
      hreq_q <= 1'b0;
      hwe_q <= 1'b0;
      hinc_pend_q <= 1'b0;
    end
  end

  // Input data register takes each prefetched byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_data_q <= 8'h00;
    end else if (h_rvalid) begin
      in_data_q <= h_rdata;
    end
  end

  // ---------------- Write sequencer ----------------
  dbhp_pkg::dbhp_wstate_t ws_q;
  logic [8:0] cnt_q;  // Bytes done in the current field
  logic [1:0] mode_q;
  logic start_q;  // One-cycle start from software
  logic [7:0] dbyte_q;  // Next data byte from the buffer
  logic [15:0] crc_q;
  logic [7:0] cur_byte;
  logic last;

  // Byte-wise CRC-16 update
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ dbhp_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Byte emitted on this tick for the current field
  always_comb begin
    cur_byte = dbhp_pkg::BYTE_ZERO;
    last = 1'b0;
    case (ws_q)
      dbhp_pkg::WS_SKIP: last = (cnt_q == dbhp_pkg::N_SKIP_FF - 9'h001);
      dbhp_pkg::WS_SD_ZERO: last = (cnt_q == dbhp_pkg::N_SD_ZERO - 9'h001);
      dbhp_pkg::WS_SD_DATA: begin
        cur_byte = dbyte_q;
        last = (cnt_q == dbhp_pkg::N_SD_DATA - 9'h001);
      end
      dbhp_pkg::WS_DC_GAP: last = (cnt_q == dbhp_pkg::N_DC_GAP - 9'h001);
      dbhp_pkg::WS_DD_SYNC: begin
        cur_byte = dbhp_pkg::BYTE_SYNC;
        last = (cnt_q == dbhp_pkg::N_DD_SYNC - 9'h001);
      end
      dbhp_pkg::WS_DD_MARK: begin
        cur_byte = cnt_q[0] ? dbhp_pkg::DAM_BYTE1 : dbhp_pkg::DAM_BYTE0;
        last = (cnt_q == dbhp_pkg::N_DD_MARK - 9'h001);
      end
      dbhp_pkg::WS_DD_DATA: begin
        cur_byte = dbyte_q;
        last = (cnt_q == dbhp_pkg::N_DD_DATA - 9'h001);
      end
      dbhp_pkg::WS_DD_CRC: begin
        cur_byte = cnt_q[0] ? crc_q[7:0] : crc_q[15:8];
        last = (cnt_q == dbhp_pkg::N_DD_CRC - 9'h001);
      end
      dbhp_pkg::WS_DD_TAIL: begin
        cur_byte = dbhp_pkg::BYTE_FF;
        last = 1'b1;
      end
      default: last = 1'b0;
    endcase
  end

  // Field sequencing, one step per byte time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_q <= dbhp_pkg::WS_IDLE;
      cnt_q <= 9'h000;
    end else if (ws_q == dbhp_pkg::WS_IDLE) begin
      cnt_q <= 9'h000;
      if (start_q) begin
        ws_q <= (mode_q == dbhp_pkg::MODE_DD) ? dbhp_pkg::WS_DD_FIND
          : dbhp_pkg::WS_SKIP;
      end
    end else if (ws_q == dbhp_pkg::WS_DD_FIND) begin
      if (dc_gap_found) begin
        ws_q <= dbhp_pkg::WS_DD_SYNC;
      end
    end else if (byte_tick && (ws_q != dbhp_pkg::WS_SKIP || skip_byte_seen)) begin
      cnt_q <= last ? 9'h000 : cnt_q + 9'h001;
      if (last) begin
        case (ws_q)
          dbhp_pkg::WS_SKIP: ws_q <= (mode_q == dbhp_pkg::MODE_SD)
            ? dbhp_pkg::WS_SD_ZERO : dbhp_pkg::WS_DC_GAP;
          dbhp_pkg::WS_SD_ZERO: ws_q <= dbhp_pkg::WS_SD_DATA;
          dbhp_pkg::WS_DD_SYNC: ws_q <= dbhp_pkg::WS_DD_MARK;
          dbhp_pkg::WS_DD_MARK: ws_q <= dbhp_pkg::WS_DD_DATA;
          dbhp_pkg::WS_DD_DATA: ws_q <= dbhp_pkg::WS_DD_CRC;
          dbhp_pkg::WS_DD_CRC: ws_q <= dbhp_pkg::WS_DD_TAIL;
          default: ws_q <= dbhp_pkg::WS_IDLE;
        endcase
      end
    end
  end

  // Disk pointer advances and the next byte is fetched after each data byte
  always_comb begin
    dptr_inc = byte_tick
      && (ws_q == dbhp_pkg::WS_SD_DATA || ws_q == dbhp_pkg::WS_DD_DATA);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dreq_q <= 1'b0;
      dbyte_q <= 8'h00;
    end else begin
      if (start_q || dptr_inc) begin
        dreq_q <= 1'b1;
      end else if (d_gnt) begin
        dreq_q <= 1'b0;
      end
      if (d_rvalid) begin
        dbyte_q <= d_rdata;
      end
    end
  end

  // CRC covers the mark through the last data byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_q <= dbhp_pkg::CRC_INIT;
    end else if (ws_q == dbhp_pkg::WS_DD_SYNC) begin
      crc_q <= dbhp_pkg::CRC_INIT;
    end else if (byte_tick && (ws_q == dbhp_pkg::WS_DD_MARK || ws_q == dbhp_pkg::WS_DD_DATA)) begin
      crc_q <= crc_upd(crc_q, cur_byte);
    end
  end

  // Write outputs; the skip field keeps the gate off so old gap bytes stay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_gate <= 1'b0;
      wr_byte <= 8'h00;
      wr_byte_valid <= 1'b0;
      wr_fm <= 1'b1;
      wr_silent <= 1'b0;
    end else begin
      wr_gate <= ws_q != dbhp_pkg::WS_IDLE && ws_q != dbhp_pkg::WS_SKIP
        && ws_q != dbhp_pkg::WS_DD_FIND;
      wr_silent <= ws_q == dbhp_pkg::WS_DC_GAP;
      wr_fm <= ws_q != dbhp_pkg::WS_DD_SYNC && ws_q != dbhp_pkg::WS_DD_DATA
        && ws_q != dbhp_pkg::WS_DD_TAIL;
      wr_byte_valid <= byte_tick && wr_gate && ws_q != dbhp_pkg::WS_DC_GAP;
      if (byte_tick) begin
        wr_byte <= cur_byte;
      end
    end
  end

  // Completion raises the request line until acknowledged; a new end wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_n <= 1'b1;
    end else if (byte_tick && last && ws_q != dbhp_pkg::WS_SKIP
        && (ws_q == dbhp_pkg::WS_DD_TAIL || ws_q == dbhp_pkg::WS_DC_GAP
        || ws_q == dbhp_pkg::WS_SD_DATA)) begin
      irq_n <= 1'b0;
    end else if (!irq_ack_n && sel) begin
      irq_n <= 1'b1;
    end
  end

  // ---------------- AXI4-Lite slave ----------------
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_axi_q;
  logic [3:0] wstrb_q;

  // Address and data are taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_axi_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_axi_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == dbhp_pkg::OFS_CTRL
          || awaddr_q == dbhp_pkg::OFS_STAT_BYTE) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Readies pulse one cycle after a valid is seen, so every output stays registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !s_axi_awready && !aw_hold_q && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready <= !s_axi_wready && !w_hold_q && !s_axi_bvalid && s_axi_wvalid;
    end
  end

  // Register writes, committed when the response is raised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
      mode_q <= dbhp_pkg::MODE_SD;
      stat_byte_q <= dbhp_pkg::STAT_BYTE_RST;
    end else begin
      start_q <= 1'b0;
      if (aw_hold_q && w_hold_q && !s_axi_bvalid && wstrb_q[0]) begin
        if (awaddr_q == dbhp_pkg::OFS_CTRL) begin
          mode_q <= wdata_axi_q[dbhp_pkg::CTRL_MODE_LSB +: 2];
          start_q <= wdata_axi_q[dbhp_pkg::CTRL_START_BIT]
            && ws_q == dbhp_pkg::WS_IDLE;
        end else if (awaddr_q == dbhp_pkg::OFS_STAT_BYTE) begin
          stat_byte_q <= wdata_axi_q[7:0];
        end
      end
    end
  end

  // Reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        s_axi_rdata <= 32'h0000_0000;
        if (s_axi_araddr[7:0] == dbhp_pkg::OFS_CTRL) begin
          s_axi_rdata[dbhp_pkg::CTRL_MODE_LSB +: 2] <= mode_q;
        end else if (s_axi_araddr[7:0] == dbhp_pkg::OFS_STATUS) begin
          s_axi_rdata[dbhp_pkg::ST_BUSY_BIT] <= ws_q != dbhp_pkg::WS_IDLE;
          s_axi_rdata[dbhp_pkg::ST_HPTR_LSB +: 8] <= hptr;
          s_axi_rdata[dbhp_pkg::ST_DPTR_LSB +: 8] <= dptr;
          s_axi_rdata[dbhp_pkg::ST_PAGE_BIT] <= page_q;
        end else if (s_axi_araddr[7:0] == dbhp_pkg::OFS_STAT_BYTE) begin
          s_axi_rdata[7:0] <= stat_byte_q;
        end else begin
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// >>> hdl/dbhp_pkg.sv
// Shared constants for the diskette buffer host port
package dbhp_pkg;
  // Command codes on the upper nibble of the command/address bus
  localparam logic [3:0] CMD_STATUS_RD = 4'h0;
  localparam logic [3:0] CMD_BUF_RD = 4'h1;
  localparam logic [3:0] CMD_ID_RD = 4'h3;
  localparam logic [3:0] CMD_BUF_WR = 4'hA;
  localparam logic [3:0] CMD_LOAD_HPTR = 4'hC;
  localparam logic [3:0] CMD_LOAD_PAGE = 4'hD;
  // Bus field positions
  localparam int ADDR_LSB = 0;
  localparam int CMD_LSB = 4;
  localparam int PAGE_BIT = 7;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_STAT_BYTE = 8'h08;
  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam logic [1:0] MODE_SD = 2'h0;
  localparam logic [1:0] MODE_DC_GAP = 2'h1;
  localparam logic [1:0] MODE_DD = 2'h2;
  // Status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_HPTR_LSB = 8;
  localparam int ST_DPTR_LSB = 16;
  localparam int ST_PAGE_BIT = 24;
  // Reset values
  localparam logic [7:0] STAT_BYTE_RST = 8'h00;
  localparam logic [7:0] ID_CODE_DEF = 8'h5A;  // Arbitrary neutral identity value
  // Sector layout byte counts
  localparam logic [8:0] N_SKIP_FF = 9'h009;
  localparam logic [8:0] N_SD_ZERO = 9'h008;
  localparam logic [8:0] N_SD_DATA = 9'h080;
  localparam logic [8:0] N_DC_GAP = 9'h002;
  localparam logic [8:0] N_DD_SYNC = 9'h00C;
  localparam logic [8:0] N_DD_MARK = 9'h002;
  localparam logic [8:0] N_DD_DATA = 9'h100;
  localparam logic [8:0] N_DD_CRC = 9'h002;
  localparam logic [8:0] N_DD_TAIL = 9'h001;
  // Byte values written in the sector
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_SYNC = 8'hAA;
  localparam logic [7:0] BYTE_FF = 8'hFF;
  localparam logic [7:0] DAM_BYTE0 = 8'hA1;  // Plain default mark values
  localparam logic [7:0] DAM_BYTE1 = 8'hFB;
  // CRC-16 generator and preset
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  // Write sequencer states
  typedef enum logic [3:0] {
    WS_IDLE = 4'h0,
    WS_SKIP = 4'h1,
    WS_SD_ZERO = 4'h2,
    WS_SD_DATA = 4'h3,
    WS_DC_GAP = 4'h4,
    WS_DD_FIND = 4'h5,
    WS_DD_SYNC = 4'h6,
    WS_DD_MARK = 4'h7,
    WS_DD_DATA = 4'h8,
    WS_DD_CRC = 4'h9,
    WS_DD_TAIL = 4'hA
  } dbhp_wstate_t;
endpackage

// >>> hdl/dbhp_ptr.sv
// Buffer pointer: loadable, incrementing, wrapping 8-bit counter
`timescale 1ns/1ps
module dbhp_ptr #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic inc,
  output logic [W-1:0] ptr
);
  initial begin
    if (W < 1) begin
      $error("dbhp_ptr: width must be at least 1");
    end
  end

  // Load beats increment; natural overflow wraps the top location to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr <= '0;
    end else if (load) begin
      ptr <= load_val;
    end else if (inc) begin
      ptr <= ptr + W'(1);
    end
  end
endmodule

// >>> hdl/dbhp_buf.sv
// Shared data buffer with host and disk ports and fixed arbitration
`timescale 1ns/1ps
module dbhp_buf #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic h_req,
  input wire logic h_we,
  input wire logic [AW-1:0] h_addr,
  input wire logic [7:0] h_wdata,
  output logic h_gnt,
  output logic [7:0] h_rdata,
  output logic h_rvalid,
  input wire logic d_req,
  input wire logic [AW-1:0] d_addr,
  output logic d_gnt,
  output logic [7:0] d_rdata,
  output logic d_rvalid
);
  // Storage for the whole buffer
  logic [7:0] mem [DEPTH];

  initial begin
    if (DEPTH != (1 << AW)) begin
      $error("dbhp_buf: depth must equal two to the address width");
    end
  end

  // Disk side wins a tie: it runs at media rate and cannot wait long
  always_comb begin
    d_gnt = d_req;
    h_gnt = h_req && !d_req;
  end

  // Single access per cycle; random access by any address
  always_ff @(posedge aclk) begin
    if (h_gnt && h_we) begin
      mem[h_addr] <= h_wdata;
    end
  end

  // Registered read data for both ports
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_rdata <= 8'h00;
      h_rvalid <= 1'b0;
      d_rdata <= 8'h00;
      d_rvalid <= 1'b0;
    end else begin
      h_rvalid <= h_gnt && !h_we;
      d_rvalid <= d_gnt;
      if (h_gnt && !h_we) begin
        h_rdata <= mem[h_addr];
      end
      if (d_gnt) begin
        d_rdata <= mem[d_addr];
      end
    end
  end
endmodule

// >>> verification/dbhp_host.sv
// Host processor model for the parallel microbus
`timescale 1ns/1ps
module dbhp_host (
  input wire logic aclk,
  output logic [7:0] cmd_addr_n,
  output logic [7:0] data_in,
  output logic in_strobe_n,
  output logic out_strobe_n,
  output logic irq_ack_n
);
  // Idle bus: nothing asserted on the low-true lines
  initial begin
    cmd_addr_n = 8'hFF;
    data_in = 8'h00;
    in_strobe_n = 1'b1;
    out_strobe_n = 1'b1;
    irq_ack_n = 1'b1;
  end
  // One strobed command; hold sets a prompt or slow host
  task automatic cycle(input logic [3:0] cmd, input logic [3:0] adr, input logic [7:0] d,
    input bit rd, input int hold);
    @(posedge aclk);
    cmd_addr_n <= ~{cmd, adr};
    data_in <= d;
    repeat (2) @(posedge aclk);
    if (rd) in_strobe_n <= 1'b0;
    else out_strobe_n <= 1'b0;
    repeat (hold) @(posedge aclk);
    in_strobe_n <= 1'b1;
    out_strobe_n <= 1'b1;
    // Gap before the next command lets the prefetch land
    repeat (8) @(posedge aclk);
    data_in <= ~d;
  endtask
  // Interrupt acknowledge while addressing the device
  task automatic ack(input logic [3:0] adr);
    @(posedge aclk);
    cmd_addr_n <= ~{4'h0, adr};
    irq_ack_n <= 1'b0;
    repeat (2) @(posedge aclk);
    irq_ack_n <= 1'b1;
  endtask
endmodule

// >>> verification/dbhp_top_sva.sv
// Checker for microbus and write channel outputs
`timescale 1ns/1ps
module dbhp_top_sva #(
  parameter logic [7:0] ID_CODE = dbhp_pkg::ID_CODE_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] cmd_addr_n,
  input wire logic [3:0] jumper_addr,
  input wire logic in_strobe_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic byte_tick,
  input wire logic wr_gate,
  input wire logic wr_byte_valid,
  input wire logic wr_fm,
  input wire logic wr_silent,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Device address match on the low-true bus
  wire hit = (~cmd_addr_n[3:0]) == jumper_addr;
  // Addressed input strobe carrying the identity command
  sequence s_id_req;
    !in_strobe_n && hit && (~cmd_addr_n[7:4] == dbhp_pkg::CMD_ID_RD);
  endsequence
  a_id_answer: assert property (s_id_req |=> data_oe && data_out == ID_CODE)
    else $error("identity byte not driven");
  a_foreign_quiet: assert property (!hit |=> !data_oe)
    else $error("drove bus while not addressed");
  a_idle_zero: assert property (!data_oe |-> data_out == 8'h00)
    else $error("data out not quiet");
  a_read_release: assert property (in_strobe_n [*2] |-> !data_oe)
    else $error("bus held after strobe");
  a_gap_gated: assert property (wr_silent |-> wr_gate && wr_fm)
    else $error("silent gap without gate");
  a_gap_no_pulse: assert property (wr_silent |-> !wr_byte_valid)
    else $error("pulse in gap");
  a_byte_after_tick: assert property (wr_byte_valid |-> $past(byte_tick))
    else $error("byte without tick");
  a_rd_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule
bind dbhp_top dbhp_top_sva #(.ID_CODE(ID_CODE)) dbhp_top_sva_i (.aclk, .aresetn, .cmd_addr_n,
  .jumper_addr, .in_strobe_n, .data_out, .data_oe, .byte_tick, .wr_gate, .wr_byte_valid,
  .wr_fm, .wr_silent, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready);

// >>> verification/dbhp_top_bench.sv
// Self-checking bench for the diskette buffer host port
`timescale 1ns/1ps
module dbhp_top_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] jumper_addr = 4'h0;
  logic byte_tick = 1'b0, skip_byte_seen = 1'b0, dc_gap_found = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] data_out, wr_byte, cmd_addr_n, data_in;
  logic data_oe, irq_n, wr_gate, wr_byte_valid, wr_fm, wr_silent;
  logic in_strobe_n, out_strobe_n, irq_ack_n;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] exp_q[$];  // Bytes the host expects to see driven
  logic oe_d = 1'b0;
  int fails = 0, total_checks = 0;
  // 40 MHz clock
  always #12.5 aclk = ~aclk;
  dbhp_host dbhp_host_i (.aclk, .cmd_addr_n, .data_in, .in_strobe_n, .out_strobe_n, .irq_ack_n);
  dbhp_top dbhp_top_i (.aclk, .aresetn, .cmd_addr_n, .data_in, .data_out, .data_oe,
    .in_strobe_n, .out_strobe_n, .irq_n, .irq_ack_n, .jumper_addr, .byte_tick,
    .skip_byte_seen, .dc_gap_found, .wr_gate, .wr_byte, .wr_byte_valid, .wr_fm, .wr_silent,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Oldest note is compared whenever the device starts driving
  always @(posedge aclk) begin
    oe_d <= data_oe;
    if (data_oe === 1'b1 && oe_d === 1'b0) begin
      if (exp_q.size() == 0) chk("unasked drive", 32'h1, 32'h0);
      else chk("bus byte", {24'h0, data_out}, {24'h0, exp_q.pop_front()});
    end
  end
  // Write with address and data offered together; waits for the response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, s_axi_bresp}, 32'h0);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Start a sector write, give n byte times, expect the request only at the end
  task automatic run(input logic [1:0] m, input int n);
    axi_wr(dbhp_pkg::OFS_CTRL, {29'h0, m, 1'b1});
    repeat (n) begin
      repeat (3) @(posedge aclk);
      chk("early irq", {31'h0, irq_n}, 32'h1);
      byte_tick <= 1'b1;
      @(posedge aclk);
      byte_tick <= 1'b0;
    end
    repeat (3) @(posedge aclk);
    chk("done irq", {31'h0, irq_n}, 32'h0);
    dbhp_host_i.ack(jumper_addr);
    repeat (3) @(posedge aclk);
    chk("irq cleared", {31'h0, irq_n}, 32'h1);
  endtask
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] sb, b0, b1;
    void'($urandom(32'h8eb2));
    jumper_addr <= 4'($urandom);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    sb = 8'($urandom);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    axi_wr(dbhp_pkg::OFS_STAT_BYTE, {24'h0, sb});
    exp_q.push_back(sb);
    dbhp_host_i.cycle(dbhp_pkg::CMD_STATUS_RD, jumper_addr, 8'h00, 1, 4);
    exp_q.push_back(dbhp_pkg::ID_CODE_DEF);
    dbhp_host_i.cycle(dbhp_pkg::CMD_ID_RD, jumper_addr, 8'h00, 1, 1);
    dbhp_host_i.cycle(dbhp_pkg::CMD_ID_RD, jumper_addr ^ 4'h1, 8'h00, 1, 2);
    // Write across the top of the buffer, then reload explicitly
    dbhp_host_i.cycle(dbhp_pkg::CMD_LOAD_HPTR, jumper_addr, 8'hFF, 0, 2);
    dbhp_host_i.cycle(dbhp_pkg::CMD_BUF_WR, jumper_addr, b0, 0, 1);
    dbhp_host_i.cycle(dbhp_pkg::CMD_BUF_WR, jumper_addr, b1, 0, 3);
    axi_rd(dbhp_pkg::OFS_STATUS, d, r);
    chk("host pointer", {24'h0, d[dbhp_pkg::ST_HPTR_LSB +: 8]}, 32'h1);
    dbhp_host_i.cycle(dbhp_pkg::CMD_LOAD_HPTR, jumper_addr, 8'hFF, 0, 2);
    exp_q.push_back(b0);
    exp_q.push_back(b1);
    repeat (2) dbhp_host_i.cycle(dbhp_pkg::CMD_BUF_RD, jumper_addr, 8'h00, 1, 2);
    dbhp_host_i.cycle(dbhp_pkg::CMD_LOAD_PAGE, jumper_addr, 8'h80, 0, 2);
    axi_rd(dbhp_pkg::OFS_STATUS, d, r);
    chk("page and disk pointer", {23'h0, d[24:16]}, 32'h100);
    axi_rd(8'h0C, d, r);
    chk("unmapped resp", {30'h0, r}, 32'h2);
    // Gap write: nine skipped bytes, then two silent gated bytes
    skip_byte_seen <= 1'b1;
    dc_gap_found <= 1'b1;
    run(dbhp_pkg::MODE_DC_GAP, 11);
    // Single density 9+8+128 byte times; double density 12+2+256+2+1
    run(dbhp_pkg::MODE_SD, 145);
    run(dbhp_pkg::MODE_DD, 273);
    test_done();
  end
  // Watchdog, far beyond the expected run of about two thousand cycles
  initial begin
    #200us;
    fails++;
    test_done();
  end
endmodule
